// file: core/owc_cnt_if.sv
interface owc_cnt_if;
   logic run;
   logic restart;
   logic tick;
   logic [7:0] cmp_high;
   logic [15:0] count;
   logic match;
   modport ctl (output run, output restart, output tick, output cmp_high,
      input count, input match);
   modport cnt (input run, input restart, input tick, input cmp_high,
      output count, output match);
endinterface : owc_cnt_if

// file: core/owc_counter.sv
module owc_counter (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control side
   owc_cnt_if.cnt c
);
   import owc_pkg::*;

   typedef struct packed {
      logic [15:0] count;
      logic match;
   } owc_cnt_st_t;

   owc_cnt_st_t q, d;
   logic [15:0] nxt;

   always_comb begin
      d = q;
      d.match = 1'b0;
      nxt = q.count + 16'h0001;
      if (c.restart) begin
         d.count = 16'h0000; // RL2
      end else if (c.run && c.tick) begin
         // Low compare byte plays no part
         if (nxt[15:8] == c.cmp_high) begin // RL12
            d.count = 16'h0000; // RL3
            d.match = 1'b1;
         end else begin
            d.count = nxt; // RL14
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0; // RL14
      end else begin
         q <= d;
      end
   end

   assign c.count = q.count;
   assign c.match = q.match;

   chk_match_clears: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      c.match |-> c.count == 16'h0000) else $error("count not cleared on match");
   chk_match_cause: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      c.match |-> $past(c.run && c.tick && !c.restart)
         && $past(c.count[15:8]) + 8'h01 == $past(c.cmp_high)
         || $past(c.count) == 16'hFFFF)
      else $error("match without cause");
   chk_hold_stopped: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
      !c.run && !c.restart |=> $stable(c.count) && !c.match)
      else $error("counter moved while stopped");
   chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
      c.run && c.tick && !c.restart && c.count[7:0] != 8'hFF
         |=> c.count == $past(c.count) + 16'h0001)
      else $error("counter did not step");
   chk_restart_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
      c.restart |=> c.count == 16'h0000) else $error("start did not zero");
   cov_match: cover property (@(posedge aclk) disable iff (!aresetn) c.match);
endmodule : owc_counter

// file: core/owc_pkg.sv
package owc_pkg;
   // Register address width
   localparam int AW = 5;
   // Register byte offsets
   localparam logic [4:0] OFS_SYS_CTL = 5'h00;
   localparam logic [4:0] OFS_LO_CTL = 5'h04;
   localparam logic [4:0] OFS_UP_CTL = 5'h08;
   localparam logic [4:0] OFS_CMP = 5'h0C;
   localparam logic [4:0] OFS_COUNT = 5'h10;
   localparam logic [4:0] OFS_IRQ_STS = 5'h14;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
   localparam logic [4:0] OFS_IRQ_EN = 5'h1C;
   // system_control_two fields
   localparam int SYS_FAST_EN_BIT = 7;
   localparam int SYS_SLOW_EN_BIT = 6;
   localparam int SYS_CLK_SEL_BIT = 5;
   localparam logic [7:0] SYS_CTL_RST = 8'h80;
   // Timer control fields
   localparam int TOGGLE_BIT = 7;
   localparam int SRC_LSB = 4;
   localparam int START_BIT = 3;
   localparam logic [2:0] SRC_SLOW = 3'h4;
   localparam logic [2:0] SRC_FAST = 3'h6;
   localparam logic [2:0] MODE_CASCADE_LO = 3'h3;
   localparam logic [2:0] MODE_WARMUP_UP = 3'h5;
   localparam logic [7:0] TMR_CTL_RST = 8'h00;
   localparam logic [15:0] CMP_RST = 16'h0000;
   // Useful compare span, upper byte
   localparam logic [7:0] CMP_HIGH_MIN = 8'h01;
   localparam logic [7:0] CMP_HIGH_MAX = 8'hFF;
   // Interrupt status bit
   localparam int IRQ_MATCH_BIT = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : owc_pkg

// file: core/owc_top.sv
// Function
// RL1: Software enables the slow oscillator before a slow warm-up measurement.
// RL2: Setting the upper start bit in warm-up mode counts up from zero.
// RL3: Compare match clears the counter and raises the match interrupt together; here irq_sts and irq rise one aclk cycle after the clear.
// RL4: Slow switch: stop counter, select slow clock, then disable fast oscillator.
// RL5: Software enables the fast oscillator before a fast warm-up measurement.
// RL6: Fast switch: stop counter, select fast clock, then disable slow oscillator.
// RL7: Slow source compare 0100H..FF00H gives 7.81 ms to 1.99 s.
// RL8: Fast source compare 0100H..FF00H gives 16 us to 4.08 ms.
// RL9: Slow setup writes 43H to lower control and 05H to upper control.
// RL10: Fast setup writes 63H to lower control before starting.
// RL11: System control holds fast enable bit 7, slow enable 6, clock select 5.
// RL12: Warm-up compares only the upper compare byte with the counter.
// RL13: Software keeps both toggle initial bits at zero in warm-up mode.
// RL14: Counter steps once per source tick, holds when stopped, resets to zero.
// RL15: Clearing start stops the counter at once, no further matches.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
module owc_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Source clock ticks, one cycle each
   input wire logic slow_tick,
   input wire logic fast_tick,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [owc_pkg::AW-1:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [owc_pkg::AW-1:0] araddr,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Oscillator control
   output logic fast_osc_en,
   output logic slow_osc_en,
   output logic sysclk_slow_sel,
   // Interrupt
   output logic irq
);
   import owc_pkg::*;

   typedef struct packed {
      logic aw_held;
      logic [AW-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] sys_ctl;
      logic [7:0] lo_ctl;
      logic [7:0] up_ctl;
      logic [15:0] cmp;
      logic irq_sts;
      logic irq_en;
      logic irq;
      logic run_prev;
   } owc_st_t;

   owc_st_t q, d;
   owc_cnt_if cif ();
   logic run;
   logic do_wr;

   // Word offset valid within the map
   function automatic logic owc_hit(input logic [AW-1:0] a);
      owc_hit = (a[1:0] == 2'b00) && (a[4:2] <= OFS_IRQ_EN[4:2]);
   endfunction : owc_hit

   // Byte-lane merge of an 8-bit register
   function automatic logic [7:0] owc_lane0(input logic [7:0] old,
         input logic [31:0] wd, input logic [3:0] st);
      owc_lane0 = st[0] ? wd[7:0] : old;
   endfunction : owc_lane0

   function automatic logic [31:0] owc_rd(input owc_st_t s, input logic [AW-1:0] a,
         input logic [15:0] cnt);
      owc_rd = 32'h0000_0000;
      unique case (a)
         OFS_SYS_CTL: owc_rd[7:0] = s.sys_ctl; // RL11
         OFS_LO_CTL: owc_rd[7:0] = s.lo_ctl;
         OFS_UP_CTL: owc_rd[7:0] = s.up_ctl;
         OFS_CMP: owc_rd[15:0] = s.cmp;
         OFS_COUNT: owc_rd[15:0] = cnt;
         OFS_IRQ_STS: owc_rd[IRQ_MATCH_BIT] = s.irq_sts;
         OFS_IRQ_EN: owc_rd[IRQ_MATCH_BIT] = s.irq_en;
         default: owc_rd = 32'h0000_0000;
      endcase
   endfunction : owc_rd

   // Software must keep the toggle bits at zero; not enforced here
   assign run = q.up_ctl[START_BIT] && (q.up_ctl[2:0] == MODE_WARMUP_UP)
      && (q.lo_ctl[2:0] == MODE_CASCADE_LO); // RL2 RL15

   assign cif.run = run;
   assign cif.restart = run && !q.run_prev; // RL2
   assign cif.cmp_high = q.cmp[15:8]; // RL12
   // Source field picks the tick; other codes give no tick
   assign cif.tick = (q.lo_ctl[6:4] == SRC_SLOW) ? slow_tick
      : (q.lo_ctl[6:4] == SRC_FAST) ? fast_tick : 1'b0; // RL7 RL8 RL14

   assign do_wr = q.aw_held && q.w_held && !q.bvalid;

   always_comb begin
      d = q;
      d.run_prev = run;
      // Address and data may arrive in either order
      if (awvalid && q.aw_rdy) begin
         d.aw_held = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && q.w_rdy) begin
         d.w_held = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (do_wr) begin
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = owc_hit(q.aw_addr) && q.aw_addr != OFS_COUNT
            && q.aw_addr != OFS_IRQ_STS ? RESP_OKAY : RESP_SLVERR;
         unique case (q.aw_addr)
            OFS_SYS_CTL: d.sys_ctl = owc_lane0(q.sys_ctl, q.w_data, q.w_strb); // RL11
            OFS_LO_CTL: d.lo_ctl = owc_lane0(q.lo_ctl, q.w_data, q.w_strb);
            OFS_UP_CTL: d.up_ctl = owc_lane0(q.up_ctl, q.w_data, q.w_strb);
            OFS_CMP: begin
               d.cmp[7:0] = owc_lane0(q.cmp[7:0], q.w_data, q.w_strb);
               if (q.w_strb[1]) begin
                  d.cmp[15:8] = q.w_data[15:8];
               end
            end
            OFS_IRQ_CLR: begin
               if (q.w_strb[0] && q.w_data[IRQ_MATCH_BIT]) begin
                  d.irq_sts = 1'b0;
               end
            end
            OFS_IRQ_EN: begin
               if (q.w_strb[0]) begin
                  d.irq_en = q.w_data[IRQ_MATCH_BIT];
               end
            end
            default: ;
         endcase
      end
      // A match in the clearing cycle still sets the flag
      if (cif.match) begin
         d.irq_sts = 1'b1; // RL3
      end
      d.aw_rdy = !d.aw_held && !d.bvalid;
      d.w_rdy = !d.w_held && !d.bvalid;
      if (rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && q.ar_rdy) begin
         d.rvalid = 1'b1;
         d.rdata = owc_rd(q, araddr, cif.count);
         d.rresp = owc_hit(araddr) && araddr != OFS_IRQ_CLR ? RESP_OKAY : RESP_SLVERR;
      end
      d.ar_rdy = !d.rvalid;
      d.irq = d.irq_sts && d.irq_en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.sys_ctl <= SYS_CTL_RST;
         q.lo_ctl <= TMR_CTL_RST;
         q.up_ctl <= TMR_CTL_RST;
         q.cmp <= CMP_RST;
         q.bresp <= RESP_OKAY;
         q.rresp <= RESP_OKAY;
      end else begin
         q <= d;
      end
   end

   owc_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .c(cif.cnt)
   );

   assign awready = q.aw_rdy;
   assign wready = q.w_rdy;
   assign arready = q.ar_rdy;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign fast_osc_en = q.sys_ctl[SYS_FAST_EN_BIT]; // RL11 RL5
   assign slow_osc_en = q.sys_ctl[SYS_SLOW_EN_BIT]; // RL11 RL1
   assign sysclk_slow_sel = q.sys_ctl[SYS_CLK_SEL_BIT]; // RL11 RL4 RL6
   assign irq = q.irq;

   chk_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      cif.match && q.irq_en |=> irq) else $error("match did not raise irq");
   chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      cif.match |=> q.irq_sts) else $error("match flag lost");
   chk_stop_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
      !q.up_ctl[START_BIT] |=> !cif.match) else $error("match while stopped");
   chk_osc_bits: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
      do_wr && q.aw_addr == OFS_SYS_CTL && q.w_strb[0]
         |=> fast_osc_en == $past(q.w_data[7]) && slow_osc_en == $past(q.w_data[6])
         && sysclk_slow_sel == $past(q.w_data[5])) else $error("sys control bits");
   // Write answer follows both halves by two edges at most
   chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("no write response");
   chk_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready |=> rvalid) else $error("no read response");

   // Answers stand until taken, and the slave refuses while busy
   chk_b_stands: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
   chk_r_stands: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read response dropped");
   chk_busy_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid |-> !awready && !wready) else $error("write taken while busy");
   chk_read_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid |-> !arready) else $error("read taken while busy");
   chk_ro_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr && (q.aw_addr == OFS_COUNT || q.aw_addr == OFS_IRQ_STS)
         |=> bresp == RESP_SLVERR) else $error("read-only write accepted");
   chk_clr_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && araddr == OFS_IRQ_CLR
         |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000)
      else $error("clear register readable");

   // Status is sticky until cleared; the line obeys the enable
   chk_sts_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
      q.irq_sts && !(do_wr && q.aw_addr == OFS_IRQ_CLR) |=> q.irq_sts)
      else $error("status lost without clear");
   chk_clear_works: assert property (@(posedge aclk) disable iff (!aresetn)
      do_wr && q.aw_addr == OFS_IRQ_CLR && q.w_strb[0] && q.w_data[IRQ_MATCH_BIT]
         && !cif.match |=> !q.irq_sts) else $error("clear ignored");
   chk_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.irq_en && !(do_wr && q.aw_addr == OFS_IRQ_EN) |=> !irq)
      else $error("irq while masked");
   chk_cmp_lands: assert property (@(posedge aclk) disable iff (!aresetn) // RL12
      do_wr && q.aw_addr == OFS_CMP && q.w_strb[1]
         |=> cif.cmp_high == $past(q.w_data[15:8])) else $error("compare byte lost");

   // Ticks of the source not selected leave the count alone
   chk_slow_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
      run && q.lo_ctl[6:4] == SRC_SLOW && !slow_tick && !cif.restart
         |=> $stable(cif.count)) else $error("slow count moved without tick");
   chk_fast_idle: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
      run && q.lo_ctl[6:4] == SRC_FAST && !fast_tick && !cif.restart
         |=> $stable(cif.count)) else $error("fast count moved without tick");

   // Reset levels, checked on the edge that ends reset
   chk_reset_levels: assert property (@(posedge aclk) // RL11 RL14
      $rose(aresetn) |-> fast_osc_en && !slow_osc_en && !sysclk_slow_sel && !irq
         && !bvalid && !rvalid && cif.count == 16'h0000)
      else $error("wrong levels after reset");
   chk_ready_release: assert property (@(posedge aclk)
      $rose(aresetn) |=> awready && wready && arready) else $error("not ready after reset");
   cov_slow_setup: cover property (@(posedge aclk) disable iff (!aresetn) // RL9
      q.lo_ctl == 8'h43 && q.up_ctl == 8'h0D && cif.match);
   cov_fast_setup: cover property (@(posedge aclk) disable iff (!aresetn) // RL10
      q.lo_ctl == 8'h63 && q.up_ctl == 8'h0D && cif.match);
   cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
   cov_span_min: cover property (@(posedge aclk) disable iff (!aresetn) // RL7 RL8
      cif.match && q.cmp[15:8] == CMP_HIGH_MIN);
endmodule : owc_top

// file: test/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import owc_pkg::*;
   logic aclk, aresetn, slow_tick, fast_tick;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic fast_osc_en, slow_osc_en, sysclk_slow_sel, irq;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   // Whole run is a few thousand cycles; generous margin
   localparam int CEIL = 20000;
   owc_top i_owc_top (.aclk(aclk), .aresetn(aresetn), .slow_tick(slow_tick),
      .fast_tick(fast_tick), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
      .sysclk_slow_sel(sysclk_slow_sel), .irq(irq));
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   task give_verdict;
      if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == CEIL) begin
         num_errors++;
         give_verdict;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ad, wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1;
      // Channels released independently as each is taken
      do begin
         @(posedge aclk);
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 0;
         end
      end while (!(ad && wd && bvalid));
      bready <= 0;
      chk(bresp, er);
   endtask : wr
   task rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
      bit ad;
      ad = 0;
      @(posedge aclk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (!ad && arready) begin
            ad = 1;
            arvalid <= 0;
         end
      end while (!(ad && rvalid));
      rready <= 0;
      chk(rdata, exp);
      chk(rresp, er);
   endtask : rd
   // Alternating gap keeps every tick a single-cycle pulse
   task pulse(input bit fast, input int n);
      repeat (n) begin
         @(posedge aclk);
         fast_tick <= fast;
         slow_tick <= !fast;
         @(posedge aclk);
         fast_tick <= 0;
         slow_tick <= 0;
      end
   endtask : pulse
   task pins(input logic [2:0] exp);
      repeat (3) @(negedge aclk);
      chk({fast_osc_en, slow_osc_en, sysclk_slow_sel}, exp);
   endtask : pins
   task irq_is(input logic exp);
      repeat (3) @(negedge aclk);
      chk(irq, exp);
   endtask : irq_is
   initial begin
      {aresetn, slow_tick, fast_tick, awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd(OFS_SYS_CTL, 32'h80, RESP_OKAY);
      rd(OFS_LO_CTL, 32'h0, RESP_OKAY);
      rd(OFS_UP_CTL, 32'h0, RESP_OKAY);
      rd(OFS_CMP, 32'h0, RESP_OKAY);
      rd(OFS_IRQ_EN, 32'h0, RESP_OKAY);
      pins(3'b100);
      irq_is(0);
      // Slow warm-up, lower compare byte set to junk on purpose
      wr(OFS_SYS_CTL, 32'hC0, RESP_OKAY);
      pins(3'b110);
      wr(OFS_LO_CTL, 32'h43, RESP_OKAY);
      wr(OFS_UP_CTL, 32'h05, RESP_OKAY);
      wr(OFS_CMP, 32'h01AB, RESP_OKAY);
      wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
      wr(OFS_UP_CTL, 32'h0D, RESP_OKAY);
      pulse(1, 10);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      pulse(0, 255);
      rd(OFS_COUNT, 32'hFF, RESP_OKAY);
      irq_is(0);
      pulse(0, 1);
      irq_is(1);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      rd(OFS_IRQ_STS, 32'h1, RESP_OKAY);
      // Service: stop, select slow, drop fast oscillator
      wr(OFS_UP_CTL, 32'h05, RESP_OKAY);
      wr(OFS_SYS_CTL, 32'hE0, RESP_OKAY);
      wr(OFS_SYS_CTL, 32'h60, RESP_OKAY);
      pins(3'b011);
      wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
      pulse(0, 300);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      rd(OFS_IRQ_STS, 32'h0, RESP_OKAY);
      irq_is(0);
      wr(OFS_UP_CTL, 32'h0D, RESP_OKAY);
      pulse(0, 5);
      wr(OFS_UP_CTL, 32'h05, RESP_OKAY);
      pulse(0, 5);
      rd(OFS_COUNT, 32'h5, RESP_OKAY);
      wr(OFS_UP_CTL, 32'h0D, RESP_OKAY);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      wr(OFS_UP_CTL, 32'h05, RESP_OKAY);
      // Fast warm-up
      wr(OFS_SYS_CTL, 32'hE0, RESP_OKAY);
      wr(OFS_LO_CTL, 32'h63, RESP_OKAY);
      wr(OFS_CMP, 32'h0200, RESP_OKAY);
      wr(OFS_UP_CTL, 32'h0D, RESP_OKAY);
      pulse(0, 10);
      pulse(1, 511);
      rd(OFS_COUNT, 32'h1FF, RESP_OKAY);
      irq_is(0);
      pulse(1, 1);
      irq_is(1);
      wr(OFS_UP_CTL, 32'h05, RESP_OKAY);
      wr(OFS_SYS_CTL, 32'hC0, RESP_OKAY);
      wr(OFS_SYS_CTL, 32'h80, RESP_OKAY);
      pins(3'b100);
      // Masking keeps status but drops the line
      wr(OFS_IRQ_EN, 32'h0, RESP_OKAY);
      irq_is(0);
      rd(OFS_IRQ_STS, 32'h1, RESP_OKAY);
      wr(OFS_IRQ_CLR, 32'h1, RESP_OKAY);
      rd(OFS_IRQ_STS, 32'h0, RESP_OKAY);
      wr(OFS_COUNT, 32'h55, RESP_SLVERR);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      rd(OFS_IRQ_CLR, 32'h0, RESP_SLVERR);
      // Reset in mid-run returns counter and controls to reset values
      wr(OFS_UP_CTL, 32'h0D, RESP_OKAY);
      pulse(1, 3);
      rd(OFS_COUNT, 32'h3, RESP_OKAY);
      wr(OFS_SYS_CTL, 32'hE0, RESP_OKAY);
      aresetn <= 0;
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd(OFS_COUNT, 32'h0, RESP_OKAY);
      rd(OFS_UP_CTL, 32'h0, RESP_OKAY);
      rd(OFS_SYS_CTL, 32'h80, RESP_OKAY);
      pins(3'b100);
      give_verdict;
   end
endmodule : tb
